// ### logic/hibernate_and_boot_sequencer.sv
`timescale 1ns/100ps

// What this block does
// - regulator enable held low for wake count whole slow-clock cycles after the first slow edge
// - at timer expiry regulator enable goes high again
// - sleep-domain state and one-time memory survive; the boot sequence starts over on wake
// - boot starts on external regulator enable or sleep-domain wake input
// - trim, package and memory-size load only after regulators are stable
// - cores power up after configuration, then crystal after cores
// - processors released last, after crystal is powered
// - one-time memory holds 768 bytes, readable after any reset
// - unprogrammed one-time memory bits read as zero
// - a bit programmed to one never returns to zero
// - whole-array or per-byte programming; only zero bits change
module hibernate_and_boot_sequencer
  import sleep_seq_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              slow_clk,
  input  wire logic [WAKE_W-1:0] wake_count,
  input  wire logic              sleep_request,
  output logic                   regulator_enable_out,
  input  wire logic              ext_reg_on,
  input  wire logic              wake_request_in,
  input  wire step_done_s        step_done,
  output step_ctl_s              step_ctl,
  output logic                   chip_reset_n,
  input  wire otm_req_s          otm_req,
  output logic [7:0]             otm_rdata,
  output logic                   otm_rvalid
);

  // ***********************************************
  // input synchronisers
  // ***********************************************
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic [4:0] slow_in;
  assign slow_in = {slow_clk, sleep_request, ext_reg_on, wake_request_in, step_done.regs_stable};

  // two flops per asynchronous input
  // the slow clock and the pins come from other domains; nothing reads sync1_q but sync2_q
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
    end else begin
      sync1_q <= slow_in;
      sync2_q <= sync1_q;
    end
  end

  logic slow_s, req_s, ext_s, wake_s, stable_s;
  assign {slow_s, req_s, ext_s, wake_s, stable_s} = sync2_q;

  // ***********************************************
  // sleep domain timer
  // ***********************************************
  logic              slow_prev_q;
  logic              req_prev_q;
  logic              sleeping_q;
  logic              armed_q;
  logic [WAKE_W-1:0] remain_q;
  logic              slow_tick;
  logic              req_rise;
  logic              start_sleep;
  logic              arm_tick;
  logic              count_tick;
  logic              last_tick;

  assign slow_tick   = slow_s & ~slow_prev_q;
  assign req_rise    = req_s & ~req_prev_q;
  assign start_sleep = req_rise & ~sleeping_q & (wake_count != WAKE_RST);
  // the first slow edge after the drop only aligns the count, so every counted
  // cycle is a whole slow period and the output never rises early
  assign arm_tick    = sleeping_q & ~armed_q & slow_tick;
  assign count_tick  = sleeping_q & armed_q & slow_tick;
  assign last_tick   = count_tick & (remain_q == 24'h00_0001);

  // edge history for slow clock and request
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      slow_prev_q <= 1'b0;
      req_prev_q  <= 1'b0;
    end else begin
      slow_prev_q <= slow_s;
      req_prev_q  <= req_s;
    end
  end

  // countdown of slow-clock cycles; retained through sleep like the one-time memory
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sleeping_q <= 1'b0;
      armed_q    <= 1'b0;
      remain_q   <= WAKE_RST;
    end else if (start_sleep) begin
      sleeping_q <= 1'b1;
      armed_q    <= 1'b0;
      remain_q   <= wake_count;
    end else if (last_tick) begin
      sleeping_q <= 1'b0;
      armed_q    <= 1'b0;
      remain_q   <= WAKE_RST;
    end else if (arm_tick) begin
      armed_q    <= 1'b1;
    end else if (count_tick) begin
      remain_q   <= remain_q - 24'h00_0001;
    end
  end

  // output rests high, low only while sleeping_q is set
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      regulator_enable_out <= 1'b1;
    end else begin
      regulator_enable_out <= ~(start_sleep | (sleeping_q & ~last_tick));
    end
  end

  // ***********************************************
  // boot sequencer
  // ***********************************************
  boot_state_e state_q, state_d;
  logic        enable_in;
  assign enable_in = ext_s | wake_s;

  // next step only on completion of the current one
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_OFF:   if (enable_in) state_d = ST_REG;
      ST_REG:   if (stable_s) state_d = ST_TRIM;
      ST_TRIM:  if (step_done.trim_done) state_d = ST_CORES;
      ST_CORES: if (step_done.cores_up) state_d = ST_XTAL;
      ST_XTAL:  if (step_done.xtal_up) state_d = ST_BOOT;
      ST_BOOT:  state_d = ST_RUN;
      ST_RUN:   state_d = ST_RUN;
      default:  state_d = ST_OFF;
    endcase
    if (!enable_in) state_d = ST_OFF;
    // a sleeping chip has no powered cores, so the sequence starts over on wake
    if (sleeping_q) state_d = ST_OFF;
  end

  // state register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // step enables held while at or past their step
  logic [6:0] st;
  assign st = state_q;

  // cumulative step decode: each enable stays on while at or past its step
  logic       at_trim;
  logic       at_cores;
  logic       at_xtal;
  logic       at_boot;
  assign at_trim  = |st[6:2];
  assign at_cores = |st[6:3];
  assign at_xtal  = |st[6:4];
  assign at_boot  = |st[6:5];

  // registered enables towards the power hardware
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      step_ctl     <= '0;
      chip_reset_n <= 1'b0;
    end else begin
      step_ctl.trim_load   <= at_trim;
      step_ctl.cores_on    <= at_cores;
      step_ctl.xtal_on     <= at_xtal;
      step_ctl.cpu_release <= at_boot;
      chip_reset_n         <= at_boot;
    end
  end

  // ***********************************************
  // one-time configuration memory
  // ***********************************************
  // array is not cleared by reset; only ones can be added
  // blank fuses read as zero from power-up; rst_n never touches the contents
  logic [7:0] otm_q [OTM_BYTES] = '{default: OTM_BLANK};
  logic       addr_ok;
  assign addr_ok = otm_req.addr < 10'(OTM_BYTES);

  genvar gi;
  generate
    for (gi = 0; gi < OTM_BYTES; gi++) begin : g_otm
      logic hit;
      assign hit = otm_req.prog & (otm_req.prog_all | (otm_req.addr == 10'(gi)));
      always_ff @(posedge core_clk) begin
        if (hit) begin
          otm_q[gi] <= otm_q[gi] | otm_req.wdata;
        end
      end
    end
  endgenerate

  // byte select; addresses past the array read as blank
  logic [7:0] rd_byte;
  assign rd_byte = addr_ok ? otm_q[otm_req.addr] : OTM_BLANK;

  // read port, valid one cycle after request
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      otm_rdata  <= OTM_BLANK;
      otm_rvalid <= 1'b0;
    end else begin
      otm_rvalid <= otm_req.rd;
      otm_rdata  <= rd_byte;
    end
  end

endmodule : hibernate_and_boot_sequencer

// ### logic/sleep_seq_pkg.sv
package sleep_seq_pkg;

  // ***********************************************
  // sizes and reset values
  // ***********************************************
  localparam int unsigned WAKE_W        = 24;
  localparam int unsigned OTM_BITS      = 6144;
  localparam int unsigned OTM_BYTES     = 768;
  localparam int unsigned OTM_AW        = 10;
  localparam logic [7:0]  OTM_BLANK     = 8'h00;
  localparam logic [WAKE_W-1:0] WAKE_RST = 24'h00_0000;
  // slow and core clock rates in Hz
  localparam int unsigned SLOW_CLK_HZ   = 32000;
  localparam int unsigned CORE_CLK_HZ   = 10000000;

  // boot sequencer states, one-hot
  typedef enum logic [6:0] {
    ST_OFF    = 7'b000_0001,
    ST_REG    = 7'b000_0010,
    ST_TRIM   = 7'b000_0100,
    ST_CORES  = 7'b000_1000,
    ST_XTAL   = 7'b001_0000,
    ST_BOOT   = 7'b010_0000,
    ST_RUN    = 7'b100_0000
  } boot_state_e;

  // step completion reports from the power hardware
  typedef struct packed {
    logic regs_stable;
    logic trim_done;
    logic cores_up;
    logic xtal_up;
  } step_done_s;

  // enables driven to the power hardware
  typedef struct packed {
    logic trim_load;
    logic cores_on;
    logic xtal_on;
    logic cpu_release;
  } step_ctl_s;

  // one-time memory access
  typedef struct packed {
    logic              rd;
    logic              prog;
    logic              prog_all;
    logic [OTM_AW-1:0] addr;
    logic [7:0]        wdata;
  } otm_req_s;

endpackage : sleep_seq_pkg

// ### tb/power_partner.sv
`timescale 1ns/100ps
// *****
// power hardware model
// *****
module power_partner
  import sleep_seq_pkg::*;
(
  input wire logic      core_clk,
  input wire logic      reg_on,
  input wire step_ctl_s step_ctl,
  output step_done_s    step_done
);
  logic [3:0] d1_q;
  logic [3:0] d2_q;
  // each step reports done two cycles after its enable and drops two cycles after it
  always_ff @(posedge core_clk) begin
    d1_q <= {reg_on, step_ctl.trim_load, step_ctl.cores_on, step_ctl.xtal_on};
    d2_q <= d1_q;
  end
  assign step_done = d2_q;
endmodule : power_partner

// ### tb/sleep_seq_checker.sv
`timescale 1ns/100ps
// *****
// sequencer checks
// *****
module sleep_seq_checker
  import sleep_seq_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       sleep_request,
  input wire logic       regulator_enable_out,
  input wire logic       ext_reg_on,
  input wire logic       wake_request_in,
  input wire step_done_s step_done,
  input wire step_ctl_s  step_ctl,
  input wire logic       chip_reset_n,
  input wire otm_req_s   otm_req,
  input wire logic [7:0] otm_rdata,
  input wire logic       otm_rvalid
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // boot steps follow their causes
  property p_trim; $rose(step_ctl.trim_load) |-> $past(step_done.regs_stable); endproperty
  a_trim: assert property (p_trim) else $error("trim before stable");
  property p_cores; $rose(step_ctl.cores_on) |-> step_ctl.trim_load && $past(step_done.trim_done); endproperty
  a_cores: assert property (p_cores) else $error("cores early");
  property p_xtal; $rose(step_ctl.xtal_on) |-> step_ctl.cores_on && $past(step_done.cores_up); endproperty
  a_xtal: assert property (p_xtal) else $error("xtal early");
  property p_rel; $rose(step_ctl.cpu_release) |-> chip_reset_n && step_ctl.xtal_on; endproperty
  a_rel: assert property (p_rel) else $error("release early");
  property p_idle; (!ext_reg_on && !wake_request_in) [*5] |-> step_ctl == '0; endproperty
  a_idle: assert property (p_idle) else $error("no restart");
  // regulator enable, out-of-range memory reads and covers
  property p_fall; $fell(regulator_enable_out) |-> $past(sleep_request, 2); endproperty
  a_fall: assert property (p_fall) else $error("drop unasked");
  property p_low; $fell(regulator_enable_out) |=> !regulator_enable_out [*8]; endproperty
  a_low: assert property (p_low) else $error("low too short");
  property p_oor; otm_rvalid && $past(otm_req.addr) >= 10'd768 |-> otm_rdata == 8'h00; endproperty
  a_oor: assert property (p_oor) else $error("range read");
  c_boot: cover property ($rose(step_ctl.cpu_release));
  c_sleep: cover property ($fell(regulator_enable_out));
  c_read: cover property (otm_rvalid);
endmodule : sleep_seq_checker

bind hibernate_and_boot_sequencer sleep_seq_checker chk (.*);

// ### tb/test_hibernate_and_boot_sequencer.sv
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module test_hibernate_and_boot_sequencer
  import sleep_seq_pkg::*;
;
  // *****
  // bench
  // *****
  logic core_clk = 0, rst_n = 0, slow_clk = 0, sleep_request = 0, pwr_on = 0, wake_request_in = 0;
  logic [WAKE_W-1:0] wake_count = '0;
  otm_req_s          otm_req = '0;
  logic              regulator_enable_out, chip_reset_n, otm_rvalid;
  logic [7:0]        otm_rdata;
  step_done_s        step_done;
  step_ctl_s         step_ctl;
  wire               ext_reg_on = pwr_on & regulator_enable_out;
  int                err_count = 0, n_checks = 0;
  always #50 core_clk = ~core_clk;
  always #15625 slow_clk = ~slow_clk;
  hibernate_and_boot_sequencer uut (.*);
  power_partner pm (.core_clk(core_clk), .reg_on(ext_reg_on | wake_request_in), .step_ctl(step_ctl),
                    .step_done(step_done));
  task step; @(posedge core_clk); #10; endtask : step
  task wait_boot;
    for (int i = 0; i < 300 && chip_reset_n !== 1'b1; i++) step;
    `CHK(chip_reset_n, 1'b1)
  endtask : wait_boot
  task otm(input logic [2:0] k, input logic [9:0] a, input logic [7:0] d);
    otm_req = '{k[2], k[1], k[0], a, d};
    step;
    otm_req = '0;
    step;
  endtask : otm
  task rd(input logic [9:0] a, input logic [7:0] e);
    otm_req = '{1'b1, 1'b0, 1'b0, a, 8'h00};
    step;
    `CHK(otm_rvalid, 1'b1)
    `CHK(otm_rdata, e)
    otm_req = '0;
    step;
    `CHK(otm_rvalid, 1'b0)
  endtask : rd
  task t_otm;
    otm(3'b011, 10'h000, 8'h00);
    rd(10'h005, 8'h00);
    otm(3'b010, 10'h005, 8'h0F);
    otm(3'b010, 10'h005, 8'h30);
    rd(10'h005, 8'h3F);
    otm(3'b010, 10'h005, 8'h00);
    rd(10'h005, 8'h3F);
    rd(10'h320, 8'h00);
    otm(3'b011, 10'h000, 8'h81);
    rd(10'h005, 8'hBF);
    rd(10'h2FF, 8'h81);
    $display("otm done");
  endtask : t_otm
  task t_boot;
    pwr_on = 1;
    wait_boot;
    `CHK(step_ctl, 4'hF)
    pwr_on = 0;
    repeat (8) step;
    `CHK(step_ctl, 4'h0)
    wake_request_in = 1;
    wait_boot;
    pwr_on = 1;
    step;
    wake_request_in = 0;
    $display("boot done");
  endtask : t_boot
  task t_sleep(input logic [WAKE_W-1:0] n, input logic poke);
    int c;
    c = 0;
    wake_count = n;
    sleep_request = 1;
    for (int i = 0; i < 20 && regulator_enable_out !== 1'b0; i++) step;
    while (regulator_enable_out === 1'b0 && c < 3000) begin
      step;
      c++;
      if (c == 5) `CHK(step_ctl, 4'h0)
      if (c == 10) sleep_request = 0;
      if (poke && c == 100) sleep_request = 1;
      if (c == 150) sleep_request = 0;
    end
    `CHK(c >= n * 312 && c <= (n + 1) * 313 + 5, 1'b1)
    `CHK(regulator_enable_out, 1'b1)
    wait_boot;
    $display("sleep done");
  endtask : t_sleep
  task conclude;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  // main sequence and watchdog
  initial begin
    repeat (5) @(posedge core_clk);
    #10 rst_n = 1;
    step;
    t_otm;
    t_boot;
    t_sleep(24'h00_0001, 1'b0);
    t_sleep(24'h00_0002, 1'b1);
    conclude;
  end
  initial begin
    #1_000_000;
    err_count++;
    conclude;
  end
endmodule : test_hibernate_and_boot_sequencer
